// ---- dma_sel_pkg.sv ----
// Constants for the DMA request select and channel status block
package dma_sel_pkg;
  // ==========================================================
  // Sizes
  localparam int          NUM_CHAN      = 4;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          REQSEL_W      = 8;
  localparam int          IRQ_W         = 2 * NUM_CHAN;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0]  REQSEL_OFS    = 8'h00;
  localparam logic [7:0]  IRQ_STAT_OFS  = 8'h04;
  localparam logic [7:0]  IRQ_MASK_OFS  = 8'h08;
  localparam logic [7:0]  CHAN_BASE     = 8'h10;
  localparam logic [7:0]  CHAN_STRIDE   = 8'h08;
  localparam logic [7:0]  CHAN_END      = 8'h30;
  localparam logic [2:0]  CTRL_SUB      = 3'h0;
  localparam logic [2:0]  STAT_SUB      = 3'h4;
  localparam int          CHAN_SHIFT    = 3;
  // ==========================================================
  // Request select fields
  localparam int          REQSEL_CH2_BIT = 2;
  localparam int          REQSEL_CH3_BIT = 3;
  localparam logic [7:0]  REQSEL_RST     = 8'h00;
  // ==========================================================
  // Channel status fields
  localparam int          ST_READY_BIT  = 31;
  localparam int          ST_NC_BIT     = 23;
  localparam int          ST_ABC_BIT    = 22;
  localparam int          ST_BES_BIT    = 20;
  localparam int          ST_BED_BIT    = 19;
  localparam int          ST_CONF_BIT   = 18;
  // ==========================================================
  // Channel control fields
  localparam int          CTRL_START_BIT = 0;
  localparam int          CTRL_NIE_BIT   = 1;
  localparam int          CTRL_AIE_BIT   = 2;
  localparam logic [1:0]  CTRL_EN_RST    = 2'h0;
  localparam logic [7:0]  IRQ_RST        = 8'h00;
endpackage

// ---- dma_chan_status.sv ----
// Per-channel ready state and completion status flags
`timescale 1ns/1ns
module dma_chan_status (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Software actions
  input  wire logic start_try,
  input  wire logic stat_wr,
  input  wire logic wd_nc,
  input  wire logic wd_abc,
  // Transfer engine events
  input  wire logic done_ok,
  input  wire logic done_err,
  input  wire logic src_fault,
  input  wire logic dst_fault,
  input  wire logic conf_fault,
  // Status
  output logic      ready_ff,
  output logic      nc_ff,
  output logic      abc_ff,
  output logic      bes_ff,
  output logic      bed_ff,
  output logic      conf_ff,
  output logic      start_pulse_ff,
  output logic      nc_set,
  output logic      abc_set
);
  logic reject;
  logic accept;
  logic abc_clr;

  // ==========================================================
  // Start check
  assign reject  = start_try & (nc_ff | abc_ff);              // see (R7) see (R10)
  assign accept  = start_try & ~nc_ff & ~abc_ff & ~ready_ff;
  assign nc_set  = done_ok & ready_ff;
  assign abc_set = (done_err & ready_ff) | reject;           // see (R15)
  assign abc_clr = stat_wr & ~wd_abc;

  // ==========================================================
  // Ready state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
    end else if (accept) begin
      ready_ff <= 1'b1;                                       // see (R4)
    end else if (done_ok | done_err) begin
      ready_ff <= 1'b0;                                       // see (R4)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pulse_ff <= 1'b0;
    end else begin
      start_pulse_ff <= accept;                               // see (R15)
    end
  end

  // ==========================================================
  // Completion flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nc_ff <= 1'b0;
    end else if (nc_set) begin
      nc_ff <= 1'b1;                                          // see (R5)
    end else if (stat_wr && !wd_nc) begin
      nc_ff <= 1'b0;                                          // see (R6)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abc_ff <= 1'b0;
    end else if (abc_set) begin
      abc_ff <= 1'b1;                                         // see (R8)
    end else if (abc_clr) begin
      abc_ff <= 1'b0;                                         // see (R9)
    end
  end

  // ==========================================================
  // Error detail flags, software cannot write them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bes_ff  <= 1'b0;
      bed_ff  <= 1'b0;
      conf_ff <= 1'b0;
    end else begin
      if (src_fault) begin
        bes_ff <= 1'b1;                                       // see (R11)
      end else if (abc_clr) begin
        bes_ff <= 1'b0;                                       // see (R9) see (R16)
      end
      if (dst_fault) begin
        bed_ff <= 1'b1;                                       // see (R12)
      end else if (abc_clr) begin
        bed_ff <= 1'b0;                                       // see (R9)
      end
      if (conf_fault | reject) begin
        conf_ff <= 1'b1;                                      // see (R13) see (R15)
      end else if (abc_clr) begin
        conf_ff <= 1'b0;                                      // see (R9)
      end
    end
  end
endmodule

// ---- dma_req_status.sv ----
// Top: APB registers, request source routing and channel status of the DMA controller
//
// Notes on behaviour
// (R1) Channel 3 requests come from the external pin when select bit 3 is 1, else from the interrupt controller.
// (R2) Channel 2 requests come from the external pin when select bit 2 is 1, else from the interrupt controller.
// (R3) Software keeps select bits 0, 1 and 7:4 at zero.
// (R4) Status bit 31 is read-only and reads 1 exactly while the channel is Ready, 0 after reset.
// (R5) Bit 23 is set on normal completion and raises the channel interrupt when its enable is set.
// (R6) Writing 0 to bit 23 clears it and its interrupt; writing 1 leaves it.
// (R7) A start attempt while bit 23 is 1 is an error and starts nothing.
// (R8) Bit 22 is set on error completion and raises the channel interrupt when its enable is set.
// (R9) Writing 0 to bit 22 clears it, its interrupt and bits 20, 19 and 18; writing 1 leaves it.
// (R10) A start attempt while bit 22 is 1 is an error.
// (R11) Read-only bit 20 sets on a bus error in the source read cycle.
// (R12) Read-only bit 19 sets on a bus error in the destination write cycle.
// (R13) Read-only bit 18 reads 1 while a configuration error is present; the code latches it until bit 22 is written 0.
// (R14) Software writes zero to status bits 21 and 2:0.
// (R15) A rejected start sets bits 18 and 22 and the channel does not become Ready.
// (R16) Writes to bits 31, 20, 19 and 18 are ignored.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module dma_req_status
  import dma_sel_pkg::*;
#(
  parameter int N_CH = dma_sel_pkg::NUM_CHAN
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,

  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [dma_sel_pkg::ADDR_W-1:0] paddr,
  input  wire logic [dma_sel_pkg::DATA_W-1:0] pwdata,
  output logic      [dma_sel_pkg::DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,

  // Request sources
  input  wire logic [N_CH-1:0]               interrupt_controller_req,
  input  wire logic                          ext_xfer_req_pin_ch2,
  input  wire logic                          ext_xfer_req_pin_ch3,
  output logic      [N_CH-1:0]               xfer_req,

  // Transfer engine events
  input  wire logic [N_CH-1:0]               done_ok,
  input  wire logic [N_CH-1:0]               done_err,
  input  wire logic [N_CH-1:0]               src_fault,
  input  wire logic [N_CH-1:0]               dst_fault,
  input  wire logic [N_CH-1:0]               conf_fault,
  output logic      [N_CH-1:0]               chan_start,
  output logic      [N_CH-1:0]               chan_ready,

  // Interrupts
  output logic      [N_CH-1:0]               chan_irq,
  output logic                               irq
);
  import dma_sel_pkg::*;

  // ==========================================================
  // Address decode helpers
  function automatic logic chan_hit(input logic [ADDR_W-1:0] a);
    chan_hit = (a >= CHAN_BASE) && (a < CHAN_END);
  endfunction

  function automatic logic [ADDR_W-1:0] chan_rel(input logic [ADDR_W-1:0] a);
    chan_rel = a - CHAN_BASE;
  endfunction

  function automatic logic [1:0] chan_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel      = chan_rel(a);
    chan_idx = rel[CHAN_SHIFT+1:CHAN_SHIFT];
  endfunction

  function automatic logic [2:0] chan_sub(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel      = chan_rel(a);
    chan_sub = rel[CHAN_SHIFT-1:0];
  endfunction

  // ==========================================================
  // Declarations
  logic [REQSEL_W-1:0] request_source_select_reg_ff;
  logic [IRQ_W-1:0]    irq_stat_ff;
  logic [IRQ_W-1:0]    irq_mask_ff;
  logic [N_CH-1:0]     normal_done_irq_enable_ff;
  logic [N_CH-1:0]     error_done_irq_enable_ff;
  logic [DATA_W-1:0]   prdata_ff;
  logic [DATA_W-1:0]   nxt_prdata;
  logic [N_CH-1:0]     xfer_req_ff;
  logic [N_CH-1:0]     chan_irq_ff;
  logic                irq_ff;
  logic [N_CH-1:0]     nxt_xfer_req;
  logic [DATA_W-1:0]   ctrl_word;
  logic [DATA_W-1:0]   stat_word;

  // Bus decode
  logic                setup;
  logic                access;
  logic                wr_en;
  logic                addr_ok;
  logic                aligned;
  logic                is_reqsel;
  logic                is_istat;
  logic                is_imask;
  logic                is_chan;
  logic                is_ctrl;
  logic                is_stat;
  logic [1:0]          ch_sel;

  // Channel strobes
  logic [N_CH-1:0]     start_try;
  logic [N_CH-1:0]     stat_wr;

  // Channel status
  logic [N_CH-1:0]     ready_v;
  logic [N_CH-1:0]     nc_v;
  logic [N_CH-1:0]     abc_v;
  logic [N_CH-1:0]     bes_v;
  logic [N_CH-1:0]     bed_v;
  logic [N_CH-1:0]     conf_v;
  logic [N_CH-1:0]     start_v;

  // Completion events
  logic [N_CH-1:0]     nc_set_v;
  logic [N_CH-1:0]     abc_set_v;
  logic [N_CH-1:0]     nc_irq_v;
  logic [N_CH-1:0]     abc_irq_v;

  // Sticky status
  logic [IRQ_W-1:0]    irq_events;
  logic [IRQ_W-1:0]    irq_clr;
  logic [IRQ_W-1:0]    nxt_irq_stat;

  // ==========================================================
  // APB phases and decode
  assign setup     = psel & ~penable;
  assign access    = psel & penable;

  // Register hits
  assign aligned   = (paddr[1:0] == 2'h0);
  assign is_reqsel = aligned && (paddr == REQSEL_OFS);
  assign is_istat  = aligned && (paddr == IRQ_STAT_OFS);
  assign is_imask  = aligned && (paddr == IRQ_MASK_OFS);

  // Channel hits
  assign is_chan   = aligned && chan_hit(paddr);
  assign ch_sel    = chan_idx(paddr);
  assign is_ctrl   = is_chan && (chan_sub(paddr) == CTRL_SUB);
  assign is_stat   = is_chan && (chan_sub(paddr) == STAT_SUB);

  // Legal access
  assign addr_ok   = is_reqsel | is_istat | is_imask | is_ctrl | is_stat;
  assign wr_en     = access & pwrite & addr_ok;

  // Zero wait state slave
  assign pready    = 1'b1;
  assign pslverr   = access & ~addr_ok;
  assign prdata    = prdata_ff;

  // ==========================================================
  // Request source select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_source_select_reg_ff <= REQSEL_RST;
    end else if (wr_en && is_reqsel) begin
      request_source_select_reg_ff <= pwdata[REQSEL_W-1:0];
    end
  end

  // ==========================================================
  // Channel control: start strobe and interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      normal_done_irq_enable_ff <= '0;
      error_done_irq_enable_ff  <= '0;
    end else if (wr_en && is_ctrl) begin
      normal_done_irq_enable_ff[ch_sel] <= pwdata[CTRL_NIE_BIT];
      error_done_irq_enable_ff[ch_sel]  <= pwdata[CTRL_AIE_BIT];
    end
  end

  always_comb begin
    start_try = '0;
    if (wr_en && is_ctrl && pwdata[CTRL_START_BIT]) begin
      start_try[ch_sel] = 1'b1;
    end
  end

  always_comb begin
    stat_wr = '0;
    if (wr_en && is_stat) begin
      stat_wr[ch_sel] = 1'b1;
    end
  end

  // ==========================================================
  // Channel status instances
  for (genvar c = 0; c < N_CH; c++) begin : g_chan
    dma_chan_status u_stat (
      .pclk           (pclk),
      .presetn        (presetn),
      .start_try      (start_try[c]),
      .stat_wr        (stat_wr[c]),
      .wd_nc          (pwdata[ST_NC_BIT]),
      .wd_abc         (pwdata[ST_ABC_BIT]),
      .done_ok        (done_ok[c]),
      .done_err       (done_err[c]),
      .src_fault      (src_fault[c]),
      .dst_fault      (dst_fault[c]),
      .conf_fault     (conf_fault[c]),
      .ready_ff       (ready_v[c]),
      .nc_ff          (nc_v[c]),
      .abc_ff         (abc_v[c]),
      .bes_ff         (bes_v[c]),
      .bed_ff         (bed_v[c]),
      .conf_ff        (conf_v[c]),
      .start_pulse_ff (start_v[c]),
      .nc_set         (nc_set_v[c]),
      .abc_set        (abc_set_v[c])
    );
  end

  assign chan_start = start_v;
  assign chan_ready = ready_v;

  // ==========================================================
  // Request routing
  always_comb begin
    // Channels 0 and 1 always follow the controller
    nxt_xfer_req = interrupt_controller_req;
    if (request_source_select_reg_ff[REQSEL_CH2_BIT]) begin
      nxt_xfer_req[2] = ext_xfer_req_pin_ch2;                  // see (R2)
    end
    if (request_source_select_reg_ff[REQSEL_CH3_BIT]) begin
      nxt_xfer_req[3] = ext_xfer_req_pin_ch3;                  // see (R1)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_req_ff <= '0;
    end else begin
      xfer_req_ff <= nxt_xfer_req;
    end
  end

  assign xfer_req = xfer_req_ff;

  // ==========================================================
  // Per-channel completion interrupts
  assign nc_irq_v  = nc_v & normal_done_irq_enable_ff;        // see (R5) see (R6)
  assign abc_irq_v = abc_v & error_done_irq_enable_ff;        // see (R8) see (R9)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_irq_ff <= '0;
    end else begin
      chan_irq_ff <= nc_irq_v | abc_irq_v;
    end
  end

  assign chan_irq = chan_irq_ff;

  // ==========================================================
  // Sticky event status, write one to clear, set wins
  assign irq_events = {abc_set_v, nc_set_v};
  assign irq_clr    = (wr_en && is_istat) ? pwdata[IRQ_W-1:0] : IRQ_RST;
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= IRQ_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= IRQ_RST;
    end else if (wr_en && is_imask) begin
      irq_mask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign irq = irq_ff;

  // ==========================================================
  // Read data, captured in the setup phase
  always_comb begin
    ctrl_word               = '0;
    ctrl_word[CTRL_NIE_BIT] = normal_done_irq_enable_ff[ch_sel];
    ctrl_word[CTRL_AIE_BIT] = error_done_irq_enable_ff[ch_sel];
  end

  always_comb begin
    stat_word               = '0;
    stat_word[ST_READY_BIT] = ready_v[ch_sel];                // see (R4) see (R16)
    stat_word[ST_NC_BIT]    = nc_v[ch_sel];
    stat_word[ST_ABC_BIT]   = abc_v[ch_sel];
    stat_word[ST_BES_BIT]   = bes_v[ch_sel];                  // see (R11)
    stat_word[ST_BED_BIT]   = bed_v[ch_sel];                  // see (R12)
    stat_word[ST_CONF_BIT]  = conf_v[ch_sel];                 // see (R13)
  end

  always_comb begin
    nxt_prdata = '0;
    if (is_reqsel) begin
      nxt_prdata[REQSEL_W-1:0] = request_source_select_reg_ff;
    end else if (is_istat) begin
      nxt_prdata[IRQ_W-1:0] = irq_stat_ff;
    end else if (is_imask) begin
      nxt_prdata[IRQ_W-1:0] = irq_mask_ff;
    end else if (is_ctrl) begin
      nxt_prdata = ctrl_word;
    end else if (is_stat) begin
      nxt_prdata = stat_word;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (setup && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end
endmodule

// ---- dma_req_status_sva.sv ----
// Concurrent checks on the ports of the DMA request select and status block
`timescale 1ns/1ns
module dma_req_status_chk
  import dma_sel_pkg::*;
#(
  parameter int N_CH = dma_sel_pkg::NUM_CHAN
) (
  // Clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [dma_sel_pkg::ADDR_W-1:0] paddr,
  input  wire logic [dma_sel_pkg::DATA_W-1:0] pwdata,
  input  wire logic                           pslverr,
  // Requests
  input  wire logic [N_CH-1:0]                interrupt_controller_req,
  input  wire logic                           ext_xfer_req_pin_ch2,
  input  wire logic                           ext_xfer_req_pin_ch3,
  input  wire logic [N_CH-1:0]                xfer_req,
  // Events and status
  input  wire logic [N_CH-1:0]                done_ok,
  input  wire logic [N_CH-1:0]                done_err,
  input  wire logic [N_CH-1:0]                chan_start,
  input  wire logic [N_CH-1:0]                chan_ready,
  input  wire logic [N_CH-1:0]                chan_irq,
  input  wire logic                           irq
);
  import dma_sel_pkg::*;
  logic [1:0] sel_ff;
  logic [7:0] mask_ff;
  // ==========================================================
  // Shadows of select and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff  <= 2'h0;
      mask_ff <= 8'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == REQSEL_OFS) sel_ff <= pwdata[3:2];
      if (paddr == IRQ_MASK_OFS) mask_ff <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Checks
  chk_route_ch2: assert property (
    $past(presetn) |-> xfer_req[2] == ($past(sel_ff[0]) ? $past(ext_xfer_req_pin_ch2) : $past(interrupt_controller_req[2])))
    else $error("channel 2 request routing wrong");
  chk_route_ch3: assert property (
    $past(presetn) |-> xfer_req[3] == ($past(sel_ff[1]) ? $past(ext_xfer_req_pin_ch3) : $past(interrupt_controller_req[3])))
    else $error("channel 3 request routing wrong");
  chk_ready_rise: assert property (
    $rose(chan_ready[0]) |-> $past(psel && penable && pwrite && paddr == CHAN_BASE && pwdata[0]))
    else $error("channel 0 ready without start write");
  chk_ready_drop: assert property (
    chan_ready[0] && (done_ok[0] || done_err[0]) |=> !chan_ready[0])
    else $error("channel 0 ready kept after completion");
  chk_start_pulse: assert property (
    chan_start[0] |-> chan_ready[0] ##1 !chan_start[0])
    else $error("start pulse malformed");
  chk_irq_masked: assert property (
    $past(presetn) && mask_ff == 8'h00 && $past(mask_ff) == 8'h00 |-> !irq)
    else $error("interrupt with all sources masked");
  chk_irq_clear: assert property (
    psel && penable && pwrite && paddr == CHAN_BASE + {5'h0, STAT_SUB} && pwdata[23:22] == 2'h0
    && !chan_ready[0] |-> ##2 !chan_irq[0])
    else $error("channel 0 interrupt kept after flag clear");
  chk_slverr_mis: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
endmodule

// ---- dma_far_model.sv ----
// Model of interrupt controller, request pins and transfer engine events
`timescale 1ns/1ns
module dma_far_model (
  // Clock
  input  wire logic pclk,
  // Request sources
  output logic [3:0] interrupt_controller_req,
  output logic       ext_xfer_req_pin_ch2,
  output logic       ext_xfer_req_pin_ch3,
  // Engine events
  output logic [3:0] done_ok,
  output logic [3:0] done_err,
  output logic [3:0] src_fault,
  output logic [3:0] dst_fault,
  output logic [3:0] conf_fault
);
  // ==========================================================
  // Idle levels
  initial begin
    {interrupt_controller_req, ext_xfer_req_pin_ch2, ext_xfer_req_pin_ch3} = 6'h00;
    {done_ok, done_err, src_fault, dst_fault, conf_fault} = 20'h00000;
  end
  // Request levels, changed after an edge
  task automatic set_reqs(input logic [3:0] i, input logic e2, input logic e3);
    @(posedge pclk);
    interrupt_controller_req <= i;
    ext_xfer_req_pin_ch2 <= e2;
    ext_xfer_req_pin_ch3 <= e3;
  endtask
  // One-cycle event pulse: ok, err, source, dest, config
  task automatic pulse(input logic [4:0] k, input int c);
    @(posedge pclk);
    done_ok[c] <= k[0];
    done_err[c] <= k[1];
    src_fault[c] <= k[2];
    dst_fault[c] <= k[3];
    conf_fault[c] <= k[4];
    @(posedge pclk);
    {done_ok, done_err, src_fault, dst_fault, conf_fault} <= 20'h00000;
  endtask
endmodule

// ---- dma_req_status_tb.sv ----
// Self-checking bench of the DMA request select and channel status block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module dma_req_status_tb;
  import dma_sel_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ext2, ext3, er;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] interrupt_controller_req, xfer_req, done_ok, done_err, src_fault, dst_fault, conf_fault;
  logic [3:0] chan_start, chan_ready, chan_irq;
  int bad_count, checks_done, c, i, a, sel, istat, imask, sd;
  int rdy[4], nc[4], abc[4], source_bus_fault_flag[4], bed[4], cnf[4], nie[4], aie[4];
  // ==========================================================
  // Clock, design and far side
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  dma_req_status #(.N_CH(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interrupt_controller_req(interrupt_controller_req), .ext_xfer_req_pin_ch2(ext2), .ext_xfer_req_pin_ch3(ext3), .xfer_req(xfer_req),
    .done_ok(done_ok), .done_err(done_err), .src_fault(src_fault), .dst_fault(dst_fault),
    .conf_fault(conf_fault), .chan_start(chan_start), .chan_ready(chan_ready), .chan_irq(chan_irq), .irq(irq));
  dma_far_model far (.pclk(pclk), .interrupt_controller_req(interrupt_controller_req), .ext_xfer_req_pin_ch2(ext2), .ext_xfer_req_pin_ch3(ext3),
    .done_ok(done_ok), .done_err(done_err), .src_fault(src_fault), .dst_fault(dst_fault), .conf_fault(conf_fault));
  // ==========================================================
  // Model and bus tasks
  function automatic int smodel(int k);
    return (rdy[k] << ST_READY_BIT) | (nc[k] << ST_NC_BIT) | (abc[k] << ST_ABC_BIT) | (source_bus_fault_flag[k] << ST_BES_BIT)
      | (bed[k] << ST_BED_BIT) | (cnf[k] << ST_CONF_BIT);
  endfunction
  function automatic logic [7:0] cadr(int k);
    return CHAN_BASE + CHAN_STRIDE * 8'(k);
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_ctrl(int k, logic [31:0] d);
    int acc;
    apb(1, cadr(k), d);
    acc = 0;
    nie[k] = d[CTRL_NIE_BIT];
    aie[k] = d[CTRL_AIE_BIT];
    if (d[CTRL_START_BIT] && (nc[k] | abc[k])) begin
      abc[k] = 1;
      cnf[k] = 1;
      istat |= 1 << (k + 4);
    end else if (d[CTRL_START_BIT] && !rdy[k]) begin
      rdy[k] = 1;
      acc = 1;
    end
    @(negedge pclk);
    `CHK("chan_start", acc, chan_start[k])
  endtask
  task automatic wr_stat(int k, logic [31:0] d);
    apb(1, cadr(k) + {5'h0, STAT_SUB}, d);
    if (!d[ST_NC_BIT]) nc[k] = 0;
    if (!d[ST_ABC_BIT]) {abc[k], source_bus_fault_flag[k], bed[k], cnf[k]} = 4'h0;
  endtask
  task automatic ev(logic [4:0] kd, int k);
    far.pulse(kd, k);
    if (kd[2]) source_bus_fault_flag[k] = 1;
    if (kd[3]) bed[k] = 1;
    if (kd[4]) cnf[k] = 1;
    if (kd[0] && rdy[k]) begin
      nc[k] = 1;
      rdy[k] = 0;
      istat |= 1 << k;
    end
    if (kd[1] && rdy[k]) begin
      abc[k] = 1;
      rdy[k] = 0;
      istat |= 1 << (k + 4);
    end
  endtask
  task automatic chk(int k);
    repeat (2) @(posedge pclk);
    apb(0, cadr(k) + {5'h0, STAT_SUB}, 0);
    `CHK("status", smodel(k), rd)
    apb(0, IRQ_STAT_OFS, 0);
    `CHK("irq_stat", istat, rd)
    `CHK("chan_ready", rdy[k], chan_ready[k])
    `CHK("chan_irq", (nc[k] & nie[k]) | (abc[k] & aie[k]), chan_irq[k])
    `CHK("irq", int'((istat & imask) != 0), irq)
  endtask
  task automatic wrap_up();
    $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end
  // ==========================================================
  // Tests
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {bad_count, checks_done, istat, imask} = '0;
    for (i = 0; i < 4; i++) {rdy[i], nc[i], abc[i], source_bus_fault_flag[i], bed[i], cnf[i], nie[i], aie[i]} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    sd = $urandom(4947);
    for (a = 0; a < 'h30; a += 4) begin
      apb(0, 8'(a), 0);
      `CHK("reset value", 0, rd)
    end
    apb(1, 8'h11, 32'hffff_ffff);
    `CHK("misaligned", 1'b1, er)
    apb(0, 8'h30, 0);
    `CHK("unmapped", 1'b1, er)
    for (i = 0; i < 16; i++) begin
      sel = (i % 4) << 2;
      apb(1, REQSEL_OFS, sel);
      apb(0, REQSEL_OFS, 0);
      `CHK("select", sel, rd)
      far.set_reqs(4'($urandom), 1'($urandom), 1'($urandom));
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      a = {(sel[3] ? ext3 : interrupt_controller_req[3]), (sel[2] ? ext2 : interrupt_controller_req[2]), interrupt_controller_req[1:0]};
      `CHK("xfer_req", a, xfer_req)
    end
    imask = $urandom & 8'hff;
    apb(1, IRQ_MASK_OFS, imask);
    for (c = 0; c < 4; c++) begin
      wr_ctrl(c, 32'h7);
      chk(c);
      wr_stat(c, 32'hffdf_fff8);
      chk(c);
      ev(5'h01, c);
      chk(c);
      wr_ctrl(c, 32'h7);
      chk(c);
      wr_stat(c, 32'h0040_0000);
      chk(c);
      wr_stat(c, 32'h0);
      chk(c);
      wr_ctrl(c, 32'h7);
      ev(5'h0e, c);
      chk(c);
      wr_ctrl(c, 32'h5);
      chk(c);
      wr_stat(c, 32'h0);
      ev(5'h10, c);
      chk(c);
      wr_stat(c, 32'h0);
      apb(1, IRQ_STAT_OFS, 32'hff);
      istat = 0;
      chk(c);
    end
    wrap_up();
  end
endmodule
bind dma_req_status dma_req_status_chk #(.N_CH(N_CH)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .interrupt_controller_req(interrupt_controller_req),
  .ext_xfer_req_pin_ch2(ext_xfer_req_pin_ch2), .ext_xfer_req_pin_ch3(ext_xfer_req_pin_ch3), .xfer_req(xfer_req),
  .done_ok(done_ok), .done_err(done_err), .chan_start(chan_start), .chan_ready(chan_ready),
  .chan_irq(chan_irq), .irq(irq));
